// *** common/cfrrh_link_if.sv ***
interface cfrrh_link_if;
  logic                    cmd_strobe;
  logic [32*8-1:0]         cmd_frame;
  logic                    rsp_strobe;
  logic [32*8-1:0]         rsp_frame;
  modport converter (input cmd_strobe, input cmd_frame, output rsp_strobe, output rsp_frame);
  modport master (output cmd_strobe, output cmd_frame, input rsp_strobe, input rsp_frame);
endinterface : cfrrh_link_if

// *** common/cfrrh_pkg.sv ***
package cfrrh_pkg;
  localparam int          FRAME_BYTES      = 32;
  localparam int          SLOTS            = 16;
  localparam logic [7:0]  CMD_CYCLIC_RW    = 8'h50;
  localparam logic [15:0] CMD_IDLE         = 16'h0000;
  localparam int          BYTE_CMD         = 1;
  localparam int          BYTE_ALARM       = 2;
  localparam int          BYTE_OPTION      = 3;
  localparam int          BYTE_STATUS      = 3;
  localparam int          BYTE_CONN        = 5;
  localparam int          BYTE_SLOT0       = 7;
  localparam int          BYTE_REG_ADDR    = 23;
  localparam int          BYTE_RCMD        = 25;
  localparam int          BYTE_DATA        = 27;
  localparam int          BYTE_RSVD        = 31;
  localparam int          REQUEST_TRIGGER_BIT         = 15;
  localparam int          ACK_BIT          = 15;
  localparam int          STAT_BIT         = 14;
  localparam int          ADDR_PWR_BIT     = 7;
  // Opcode class in bits 13:12 of the command code
  localparam int          CLASS_HI         = 13;
  localparam int          CLASS_LO         = 12;
  localparam logic [1:0]  CLASS_READ       = 2'h0;
  localparam logic [1:0]  CLASS_WRITE      = 2'h1;
  localparam logic [1:0]  CLASS_MAINT      = 2'h2;
  localparam logic [1:0]  CLASS_MONITOR    = 2'h3;
  localparam int          SYS_CLK_HZ       = 50_000_000;
  localparam int          MASTER_CYCLE_NS  = 1000;
  localparam int          DOWN_CYCLE_NS    = 600;
  localparam int          MASTER_CYCLE_CLK = MASTER_CYCLE_NS / (1_000_000_000 / SYS_CLK_HZ);
  localparam int          DOWN_CYCLE_CLK   = DOWN_CYCLE_NS / (1_000_000_000 / SYS_CLK_HZ);
  localparam int          CNT_W            = 8;
  // Avalon map of the master end
  localparam logic [3:0]  A_CTRL           = 4'h0;
  localparam logic [3:0]  A_ADDR           = 4'h1;
  localparam logic [3:0]  A_CMD            = 4'h2;
  localparam logic [3:0]  A_WDATA          = 4'h3;
  localparam logic [3:0]  A_RDATA          = 4'h4;
  localparam logic [3:0]  A_RCMD           = 4'h5;
  localparam logic [3:0]  A_STAT           = 4'h6;
  localparam logic [3:0]  A_IRQ_STAT       = 4'h7;
  localparam logic [3:0]  A_IRQ_MASK       = 4'h8;
  localparam logic [3:0]  A_IO_OUT_LO      = 4'h9;
  localparam logic [3:0]  A_IO_OUT_HI      = 4'hA;
  localparam logic [3:0]  A_IO_OUT_2       = 4'hB;
  localparam logic [3:0]  A_IO_OUT_3       = 4'hC;
  localparam logic [3:0]  A_IO_IN_0        = 4'hD;
  localparam int          CTRL_GO          = 0;
  localparam int          ST_BUSY          = 0;
  localparam int          ST_CONN          = 1;
  localparam int          ST_ERR           = 2;
  localparam int          IRQ_DONE         = 0;
  localparam int          IRQ_ERR          = 1;
  localparam int          IRQ_CONN         = 2;
  localparam int          IRQ_W            = 3;
  // Start-type bits of each slot held low while disconnected
  localparam logic [7:0]  START_MASK       = 8'h03;
  typedef logic [7:0] cfrrh_byte_t;
endpackage : cfrrh_pkg

// *** src/cfrrh_converter.sv ***
module cfrrh_converter (
  input  wire logic         sys_clk,         // Clock
  input  wire logic         rst_b,           // Async reset, low
  input  wire logic         clk_en,          // Freeze when low
  cfrrh_link_if.converter   link,            // Frames to and from master
  input  wire logic         product_power,   // Downstream product powered
  input  wire logic         down_done,       // Downstream operation finished
  input  wire logic         down_xfer_err,   // Downstream transfer error
  input  wire logic         down_range_err,  // Written value out of range
  input  wire logic [31:0]  down_rdata,      // Data from product
  input  wire logic [7:0]   down_alarm,      // Product alarm code
  input  wire logic [127:0] down_io_out,     // I/O outputs from product
  output logic              down_start,      // Start downstream operation
  output logic [1:0]        down_class,      // Operation class
  output logic [7:0]        down_addr,       // Addressed item
  output logic [15:0]       down_cmd,        // Command code
  output logic [31:0]       down_wdata,      // Write data
  output logic [127:0]      down_io_in       // I/O inputs to product
);
  typedef struct packed
  {
    logic [1:0]   pwr_sync;
    logic         request_trigger_prev;
    logic         busy;
    logic         ack;
    logic         stat;
    logic         start;
    logic [1:0]   cls;
    logic [7:0]   addr;
    logic [15:0]  cmd;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic [127:0] io_in;
    logic         rsp_strobe;
    logic [255:0] rsp;
  } cfrrh_conv_s;
  cfrrh_conv_s r;
  cfrrh_conv_s next_r;
  logic        m_tick;
  logic        d_tick;

  // Separate master and downstream cycles
  cfrrh_cycle_tick #(.PERIOD(cfrrh_pkg::MASTER_CYCLE_CLK)) u_mtick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .tick    (m_tick)
  );
  cfrrh_cycle_tick #(.PERIOD(cfrrh_pkg::DOWN_CYCLE_CLK)) u_dtick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .tick    (d_tick)
  );

  function automatic logic [7:0] fbyte(input logic [255:0] f, input int n);
    fbyte = f[n*8 +: 8];
  endfunction : fbyte

  always_comb
  begin
    logic        request_trigger;
    logic [15:0] ccmd;
    logic        conn;
    logic        fall;
    fall   = 1'b0;
    request_trigger   = 1'b0;
    ccmd   = '0;
    conn   = r.pwr_sync[1];
    next_r = r;
    next_r.pwr_sync   = {r.pwr_sync[0], product_power};
    next_r.start      = 1'b0;
    next_r.rsp_strobe = 1'b0;
    if (link.cmd_strobe && fbyte(link.cmd_frame, cfrrh_pkg::BYTE_CMD) == cfrrh_pkg::CMD_CYCLIC_RW)
    begin
      ccmd = {fbyte(link.cmd_frame, cfrrh_pkg::BYTE_RCMD + 1),
              fbyte(link.cmd_frame, cfrrh_pkg::BYTE_RCMD)};
      request_trigger = ccmd[cfrrh_pkg::REQUEST_TRIGGER_BIT];
      for (int i = 0; i < cfrrh_pkg::SLOTS; i++)
        next_r.io_in[i*8 +: 8] = fbyte(link.cmd_frame, cfrrh_pkg::BYTE_SLOT0 + i);
      next_r.addr = fbyte(link.cmd_frame, cfrrh_pkg::BYTE_REG_ADDR);
      // Edge judged only against the previous frame
      if (request_trigger && !r.request_trigger_prev && !r.busy && !r.ack && conn)
      begin
        next_r.busy  = 1'b1;
        next_r.start = 1'b1;
        next_r.cmd   = ccmd;
        next_r.cls   = ccmd[cfrrh_pkg::CLASS_HI:cfrrh_pkg::CLASS_LO];
        next_r.wdata = link.cmd_frame[cfrrh_pkg::BYTE_DATA*8 +: 32];
      end
      fall = !request_trigger && r.request_trigger_prev;
      if (fall)
      begin
        next_r.ack  = 1'b0;
        next_r.stat = 1'b0;
        next_r.busy = 1'b0;
      end
      next_r.request_trigger_prev = request_trigger;
    end
    // Completion is whenever the product answers; no fixed latency
    // A late completion must not re-raise the acknowledge after a trigger fall
    if (r.busy && down_done && !fall)
    begin
      next_r.busy  = 1'b0;
      next_r.ack   = 1'b1;
      next_r.rdata = down_rdata;
      if (down_range_err || down_xfer_err)
        next_r.stat = 1'b1;
    end
    // Monitor keeps refreshing data while the trigger stays high
    if (r.ack && r.request_trigger_prev && r.cls == cfrrh_pkg::CLASS_MONITOR && d_tick && !fall)
    begin
      next_r.start = 1'b1;
      next_r.busy  = 1'b1;
      next_r.ack   = 1'b1;
    end
    if (m_tick)
    begin
      next_r.rsp_strobe = 1'b1;
      next_r.rsp        = '0;
      next_r.rsp[cfrrh_pkg::BYTE_CMD*8 +: 8]    = cfrrh_pkg::CMD_CYCLIC_RW;
      next_r.rsp[cfrrh_pkg::BYTE_ALARM*8 +: 8]  = down_alarm;
      next_r.rsp[cfrrh_pkg::BYTE_STATUS*8 +: 8] = {7'h00, r.stat};
      next_r.rsp[cfrrh_pkg::BYTE_CONN*8 +: 8]   = {7'h00, conn};
      next_r.rsp[cfrrh_pkg::BYTE_SLOT0*8 +: 128] = down_io_out;
      next_r.rsp[cfrrh_pkg::BYTE_REG_ADDR*8 +: 8] =
        {~conn | r.addr[cfrrh_pkg::ADDR_PWR_BIT], r.addr[6:0]};
      next_r.rsp[cfrrh_pkg::BYTE_RCMD*8 +: 16] =
        {r.ack, r.stat, r.cmd[13:0]};
      next_r.rsp[cfrrh_pkg::BYTE_DATA*8 +: 32] = r.rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  assign link.rsp_strobe = r.rsp_strobe;
  assign link.rsp_frame  = r.rsp;
  assign down_start      = r.start;
  assign down_class      = r.cls;
  assign down_addr       = r.addr;
  assign down_cmd        = r.cmd;
  assign down_wdata      = r.wdata;
  assign down_io_in      = r.io_in;
endmodule : cfrrh_converter

// *** src/cfrrh_cycle_tick.sv ***
module cfrrh_cycle_tick #(
  parameter int PERIOD = 2
) (
  input  wire logic sys_clk,  // Clock
  input  wire logic rst_b,    // Async reset, low
  input  wire logic clk_en,   // Freeze when low
  output logic      tick      // One-cycle pulse each period
);
  typedef struct packed
  {
    logic [cfrrh_pkg::CNT_W-1:0] cnt;
    logic                        tick;
  } cfrrh_tick_s;
  cfrrh_tick_s r;
  cfrrh_tick_s next_r;

  always_comb
  begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (r.cnt == cfrrh_pkg::CNT_W'(PERIOD - 1))
    begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end
    else
    begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  assign tick = r.tick;
endmodule : cfrrh_cycle_tick

// *** src/cfrrh_master.sv ***
module cfrrh_master (
  input  wire logic        sys_clk,        // Clock
  input  wire logic        rst_b,          // Async reset, low
  input  wire logic        clk_en,         // Freeze when low
  cfrrh_link_if.master     link,           // Frames to and from converter
  input  wire logic [3:0]  avs_address,    // Avalon word address
  input  wire logic        avs_read,       // Avalon read
  input  wire logic        avs_write,      // Avalon write
  input  wire logic [31:0] avs_writedata,  // Avalon write data
  output logic [31:0]      avs_readdata,   // Avalon read data
  output logic             avs_waitrequest,// Avalon wait
  output logic             irq             // Level interrupt
);
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_REQUEST_TRIGGER, M_DROP, M_WAIT_LOW} cfrrh_mst_e;
  typedef struct packed
  {
    cfrrh_mst_e   st;
    logic [7:0]   addr;
    logic [15:0]  cmd;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic [15:0]  rcmd;
    logic         err;
    logic         conn;
    logic         request_trigger;
    logic [2:0]   irq_st;
    logic [2:0]   irq_mask;
    logic [127:0] io_out;
    logic [255:0] rsp;
    logic [255:0] frame;
    logic         strobe;
    logic [31:0]  rd;
    logic         wait_n;
    logic         irq;
  } cfrrh_mst_s;
  cfrrh_mst_s r;
  cfrrh_mst_s next_r;
  logic       m_tick;

  cfrrh_cycle_tick #(.PERIOD(cfrrh_pkg::MASTER_CYCLE_CLK)) u_mtick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .tick    (m_tick)
  );

  always_comb
  begin
    logic [2:0]   ev;
    logic         conn_now;
    logic [255:0] cf;
    logic [7:0]   raddr;
    logic         rack;
    ev       = '0;
    next_r   = r;
    cf       = '0;
    conn_now = r.rsp[cfrrh_pkg::BYTE_CONN*8];
    raddr    = r.rsp[cfrrh_pkg::BYTE_REG_ADDR*8 +: 8];
    rack     = r.rsp[cfrrh_pkg::BYTE_RCMD*8 + cfrrh_pkg::ACK_BIT];
    next_r.strobe = 1'b0;
    if (link.rsp_strobe)
      next_r.rsp = link.rsp_frame;
    // Wait for the connection to turn on before any request
    if (conn_now && !r.conn)
      ev[cfrrh_pkg::IRQ_CONN] = 1'b1;
    next_r.conn = conn_now;
    if (!conn_now)
    begin
      next_r.request_trigger = 1'b0;
      if (r.st != M_IDLE)
        next_r.st = M_IDLE;
    end
    else
    begin
      unique case (r.st)
        M_IDLE: ;
        M_ADDR:
          if (raddr == r.addr)
          begin
            next_r.request_trigger = 1'b1;
            next_r.st   = M_REQUEST_TRIGGER;
          end
        M_REQUEST_TRIGGER:
          if (rack)
          begin
            next_r.rcmd  = r.rsp[cfrrh_pkg::BYTE_RCMD*8 +: 16];
            next_r.rdata = r.rsp[cfrrh_pkg::BYTE_DATA*8 +: 32];
            next_r.err   = r.rsp[cfrrh_pkg::BYTE_RCMD*8 + cfrrh_pkg::STAT_BIT];
            next_r.request_trigger  = 1'b0;
            next_r.st    = M_WAIT_LOW;
          end
        M_DROP: next_r.st = M_WAIT_LOW;
        M_WAIT_LOW:
          if (!rack)
          begin
            next_r.st = M_IDLE;
            ev[cfrrh_pkg::IRQ_DONE] = 1'b1;
            ev[cfrrh_pkg::IRQ_ERR]  = r.err;
          end
      endcase
    end
    next_r.wait_n = 1'b0;
    // Writes land only on the edge that sees waitrequest low
    if (avs_write && r.wait_n)
      unique case (avs_address)
          cfrrh_pkg::A_CTRL:
            if (avs_writedata[cfrrh_pkg::CTRL_GO] && r.st == M_IDLE && conn_now)
              next_r.st = M_ADDR;
          cfrrh_pkg::A_ADDR:     next_r.addr  = avs_writedata[7:0];
          cfrrh_pkg::A_CMD:      next_r.cmd   = avs_writedata[15:0];
          cfrrh_pkg::A_WDATA:    next_r.wdata = avs_writedata;
          cfrrh_pkg::A_IRQ_STAT: next_r.irq_st = r.irq_st & ~avs_writedata[2:0];
          cfrrh_pkg::A_IRQ_MASK: next_r.irq_mask = avs_writedata[2:0];
          cfrrh_pkg::A_IO_OUT_LO: next_r.io_out[31:0]   = avs_writedata;
          cfrrh_pkg::A_IO_OUT_HI: next_r.io_out[63:32]  = avs_writedata;
          cfrrh_pkg::A_IO_OUT_2:  next_r.io_out[95:64]  = avs_writedata;
          cfrrh_pkg::A_IO_OUT_3:  next_r.io_out[127:96] = avs_writedata;
          default: ;
        endcase
    if ((avs_read || avs_write) && !r.wait_n)
    begin
      next_r.wait_n = 1'b1;
      next_r.rd     = '0;
      if (avs_read)
        unique case (avs_address)
          cfrrh_pkg::A_ADDR:     next_r.rd = {24'h000000, r.addr};
          cfrrh_pkg::A_CMD:      next_r.rd = {16'h0000, r.cmd};
          cfrrh_pkg::A_WDATA:    next_r.rd = r.wdata;
          cfrrh_pkg::A_RDATA:    next_r.rd = r.rdata;
          cfrrh_pkg::A_RCMD:     next_r.rd = {16'h0000, r.rcmd};
          cfrrh_pkg::A_STAT:     next_r.rd = {29'h0, r.err, conn_now, r.st != M_IDLE};
          cfrrh_pkg::A_IRQ_STAT: next_r.rd = {29'h0, r.irq_st};
          cfrrh_pkg::A_IRQ_MASK: next_r.rd = {29'h0, r.irq_mask};
          cfrrh_pkg::A_IO_IN_0:  next_r.rd = r.rsp[cfrrh_pkg::BYTE_SLOT0*8 +: 32];
          default:               next_r.rd = '0;
        endcase
    end
    // Set wins over a simultaneous clear
    next_r.irq_st = next_r.irq_st | ev;
    next_r.irq    = |(next_r.irq_st & next_r.irq_mask);
    if (m_tick)
    begin
      next_r.strobe = 1'b1;
      cf[cfrrh_pkg::BYTE_CMD*8 +: 8] = cfrrh_pkg::CMD_CYCLIC_RW;
      for (int i = 0; i < cfrrh_pkg::SLOTS; i++)
        cf[(cfrrh_pkg::BYTE_SLOT0 + i)*8 +: 8] =
          conn_now ? r.io_out[i*8 +: 8] : (r.io_out[i*8 +: 8] & ~cfrrh_pkg::START_MASK);
      cf[cfrrh_pkg::BYTE_REG_ADDR*8 +: 8] = r.addr;
      cf[cfrrh_pkg::BYTE_RCMD*8 +: 16] = conn_now ?
        {r.request_trigger, r.cmd[14:0]} : cfrrh_pkg::CMD_IDLE;
      cf[cfrrh_pkg::BYTE_DATA*8 +: 32] = r.wdata;
      next_r.frame = cf;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  assign link.cmd_strobe = r.strobe;
  assign link.cmd_frame  = r.frame;
  assign avs_readdata    = r.rd;
  assign avs_waitrequest = ~r.wait_n & (avs_read | avs_write);
  assign irq             = r.irq;
endmodule : cfrrh_master

// *** tb/cfrrh_properties.sv ***
module cfrrh_properties (
  input wire logic         sys_clk,    // Clock
  input wire logic         rst_b,      // Async reset, low
  input wire logic         cmd_strobe, // Command frame valid
  input wire logic [255:0] cmd_frame,  // Command frame
  input wire logic         rsp_strobe, // Response frame valid
  input wire logic [255:0] rsp_frame   // Response frame
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] gap;
  logic       request_trigger_q;
  logic       ack_q;
  logic       stat_q;
  logic       seen;
  logic       conn;
  logic       start_any;

  // Any nonzero connection byte counts as connected
  assign conn = rsp_frame[40 +: 8] != 8'h00;

  always_comb
  begin
    start_any = 1'b0;
    for (int i = 0; i < 16; i++)
      start_any = start_any | (|(cmd_frame[(7 + i) * 8 +: 8] & cfrrh_pkg::START_MASK));
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap    <= 8'h00;
      request_trigger_q <= 1'b0;
      ack_q  <= 1'b0;
      stat_q <= 1'b0;
      seen   <= 1'b0;
    end
    else
    begin
      gap <= rsp_strobe ? 8'h00 : gap + 8'h01;
      if (rsp_strobe)
      begin
        seen   <= 1'b1;
        ack_q  <= rsp_frame[215];
        stat_q <= rsp_frame[214];
      end
      if (cmd_strobe)
        request_trigger_q <= cmd_frame[215];
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_rsp_code; rsp_strobe |-> rsp_frame[8 +: 8] == cfrrh_pkg::CMD_CYCLIC_RW; endproperty
  a_rsp_code: assert property (p_rsp_code) else $error("bad response code");
  property p_cmd_code; cmd_strobe |-> cmd_frame[8 +: 8] == cfrrh_pkg::CMD_CYCLIC_RW; endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad command code");
  property p_idle_cmd; cmd_strobe && !conn |-> cmd_frame[200 +: 16] == cfrrh_pkg::CMD_IDLE;
  endproperty
  a_idle_cmd: assert property (p_idle_cmd) else $error("command not idle");
  property p_start_off; cmd_strobe && !conn |-> !start_any; endproperty
  a_start_off: assert property (p_start_off) else $error("start bit while off");
  property p_ack_rise; rsp_strobe && rsp_frame[215] && !ack_q |-> request_trigger_q; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack without trigger");
  property p_ack_fall; rsp_strobe && !rsp_frame[215] && ack_q |-> !request_trigger_q; endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("ack fell early");
  property p_stat_rise; rsp_strobe && rsp_frame[214] && !stat_q |-> request_trigger_q; endproperty
  a_stat_rise: assert property (p_stat_rise) else $error("status without trigger");
  property p_stat_fall; rsp_strobe && !rsp_frame[214] && stat_q |-> !request_trigger_q; endproperty
  a_stat_fall: assert property (p_stat_fall) else $error("status fell early");
  property p_period; rsp_strobe && seen |-> gap == 8'(cfrrh_pkg::MASTER_CYCLE_CLK - 1);
  endproperty
  a_period: assert property (p_period) else $error("response spacing wrong");
  property p_pulse; cmd_strobe |=> !cmd_strobe [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("command strobe too long");
  property p_addr_echo; rsp_strobe && rsp_frame[215] |->
    rsp_frame[184 +: 7] == cmd_frame[184 +: 7]; endproperty
  a_addr_echo: assert property (p_addr_echo) else $error("address echo wrong");

  c_ack: cover property (rsp_strobe && rsp_frame[215]);
  c_stat: cover property (rsp_strobe && rsp_frame[214]);
  c_conn: cover property (rsp_strobe && conn);
endmodule : cfrrh_properties

// *** tb/test_cyclic_frame_remote_register_handshake.sv ***
module test_cyclic_frame_remote_register_handshake;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [15:0] cmd;
    logic [7:0]  addr;
    logic [31:0] wd;
    logic [31:0] rd;
    int          dly;
    logic        rerr;
    logic        xerr;
  } cfrrh_row_s;

  logic         sys_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         product_power = 1'b0;
  logic         down_done = 1'b0;
  logic         down_xfer_err = 1'b0;
  logic         down_range_err = 1'b0;
  logic [31:0]  down_rdata = 32'h0;
  logic [127:0] down_io_out = 128'h0;
  logic [3:0]   avs_address = 4'h0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic         down_start;
  logic [1:0]   down_class;
  logic [7:0]   down_addr;
  logic [15:0]  down_cmd;
  logic [31:0]  down_wdata;
  logic [127:0] down_io_in;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         irq;
  int           n_errors = 0;
  int           checks = 0;
  int           nstart = 0;
  cfrrh_row_s   cur;
  // Delays straddle the master cycle to vary acknowledge latency
  cfrrh_row_s   rows[6] = '{
    '{16'h0012, 8'h05, 32'h0, 32'h0000_03E8, 3, 1'b0, 1'b0},
    '{16'h1034, 8'h06, 32'h0000_03E8, 32'h0, 60, 1'b0, 1'b0},
    '{16'h2041, 8'h07, 32'h0, 32'h0, 150, 1'b0, 1'b0},
    '{16'h3050, 8'h08, 32'h0, 32'h0000_0100, 4, 1'b0, 1'b0},
    '{16'h1034, 8'h09, 32'h0000_FFFF, 32'h0, 5, 1'b1, 1'b0},
    '{16'h0012, 8'h0A, 32'h0, 32'h0000_0055, 5, 1'b0, 1'b1}};

  always #10 sys_clk = ~sys_clk;

  cfrrh_link_if link();

  cfrrh_converter i_cfrrh_converter (.sys_clk, .rst_b, .clk_en(1'b1), .link(link),
    .product_power, .down_done, .down_xfer_err, .down_range_err, .down_rdata,
    .down_alarm(8'h00), .down_io_out, .down_start, .down_class, .down_addr, .down_cmd,
    .down_wdata, .down_io_in);

  cfrrh_master i_cfrrh_master (.sys_clk, .rst_b, .clk_en(1'b1), .link(link), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);

  cfrrh_properties i_cfrrh_properties (.sys_clk, .rst_b, .cmd_strobe(link.cmd_strobe),
    .cmd_frame(link.cmd_frame), .rsp_strobe(link.rsp_strobe), .rsp_frame(link.rsp_frame));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= we;
    avs_read      <= !we;
    avs_writedata <= wd;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wait_bit(input logic [3:0] a, input int b, input logic val);
    logic [31:0] v;
    int          n;
    n = 0;
    do
    begin
      bus(1'b0, a, 32'h0, v);
      n++;
    end while (v[b] !== val && n < 2000);
    chk(32'(v[b]), 32'(val));
  endtask : wait_bit

  task automatic irq_is(input logic exp);
    @(negedge sys_clk);
    chk(32'(irq), 32'(exp));
    @(posedge sys_clk);
  endtask : irq_is

  // Stand-in product: answers each start after the row's delay
  always
  begin
    @(posedge sys_clk);
    if (down_start === 1'b1)
    begin
      nstart++;
      chk(32'(down_addr), 32'(cur.addr));
      chk(32'(down_class), 32'(cur.cmd[13:12]));
      chk(32'(down_cmd[13:0]), 32'(cur.cmd[13:0]));
      if (cur.cmd[13:12] == cfrrh_pkg::CLASS_WRITE)
        chk(down_wdata, cur.wd);
      repeat (cur.dly) @(posedge sys_clk);
      down_done      <= 1'b1;
      down_rdata     <= cur.rd + 32'(nstart);
      down_range_err <= cur.rerr;
      down_xfer_err  <= cur.xerr;
      @(posedge sys_clk);
      down_done <= 1'b0;
    end
  end

  initial
  begin
    logic [31:0] v;
    cur = rows[0];
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    bus(1'b1, cfrrh_pkg::A_IO_OUT_LO, 32'hFFFF_FFFF, v);
    bus(1'b1, cfrrh_pkg::A_CTRL, 32'h1, v);
    // Three master cycles for frames to cross both ways
    repeat (150) @(posedge sys_clk);
    chk(down_io_in[31:0], 32'hFCFC_FCFC);
    chk(32'(link.rsp_frame[191]), 32'h1);
    chk(32'(nstart), 32'h0);
    bus(1'b0, cfrrh_pkg::A_STAT, 32'h0, v);
    chk(32'(v[cfrrh_pkg::ST_CONN]), 32'h0);
    $display("disconnected test done");
    product_power <= 1'b1;
    down_io_out   <= {8{16'hA55A}};
    wait_bit(cfrrh_pkg::A_STAT, cfrrh_pkg::ST_CONN, 1'b1);
    repeat (150) @(posedge sys_clk);
    chk(down_io_in[31:0], 32'hFFFF_FFFF);
    bus(1'b0, cfrrh_pkg::A_IO_IN_0, 32'h0, v);
    chk(v, 32'hA55A_A55A);
    bus(1'b0, cfrrh_pkg::A_IRQ_STAT, 32'h0, v);
    chk(32'(v[cfrrh_pkg::IRQ_CONN]), 32'h1);
    irq_is(1'b0);
    bus(1'b1, cfrrh_pkg::A_IRQ_MASK, 32'h7, v);
    irq_is(1'b1);
    bus(1'b1, cfrrh_pkg::A_IRQ_STAT, 32'h4, v);
    irq_is(1'b0);
    bus(1'b0, 4'hE, 32'h0, v);
    chk(v, 32'h0);
    $display("connect and interrupt test done");
    foreach (rows[r])
    begin
      cur    = rows[r];
      nstart = 0;
      bus(1'b1, cfrrh_pkg::A_ADDR, 32'(cur.addr), v);
      bus(1'b1, cfrrh_pkg::A_CMD, 32'(cur.cmd), v);
      bus(1'b1, cfrrh_pkg::A_WDATA, cur.wd, v);
      bus(1'b1, cfrrh_pkg::A_CTRL, 32'h1, v);
      wait_bit(cfrrh_pkg::A_IRQ_STAT, cfrrh_pkg::IRQ_DONE, 1'b1);
      wait_bit(cfrrh_pkg::A_STAT, cfrrh_pkg::ST_BUSY, 1'b0);
      bus(1'b0, cfrrh_pkg::A_IRQ_STAT, 32'h0, v);
      chk(32'(v[cfrrh_pkg::IRQ_ERR]), 32'(cur.rerr | cur.xerr));
      bus(1'b0, cfrrh_pkg::A_RDATA, 32'h0, v);
      if (cur.cmd[13:12] == cfrrh_pkg::CLASS_READ && !cur.xerr)
        chk(v, cur.rd + 32'h1);
      if (cur.cmd[13:12] == cfrrh_pkg::CLASS_MONITOR)
        chk(32'(nstart >= 2), 32'h1);
      bus(1'b1, cfrrh_pkg::A_IRQ_STAT, 32'h7, v);
      $display("transfer %0d done", r);
    end
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : test_cyclic_frame_remote_register_handshake
